// ---- logic/ust_pkg.sv ----
// constants, field layout and carrier types of the synchronous serial transmit port
package ust_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    typedef logic [ADDR_W-1:0] ustAddr_t;
    typedef logic [DATA_W-1:0] ustByte_t;

    // register offsets
    localparam ustAddr_t XMIT_CTRL_OFS  = 3'h0;
    localparam ustAddr_t RECV_CTRL_OFS  = 3'h1;
    localparam ustAddr_t FLAG_OFS       = 3'h2;
    localparam ustAddr_t IRQ_EN_OFS     = 3'h3;
    localparam ustAddr_t XMIT_BUF_OFS   = 3'h4;
    localparam ustAddr_t BAUD_DIV_OFS   = 3'h5;
    localparam ustAddr_t RECV_DATA_OFS  = 3'h6;

    // transmit status/control fields
    localparam int CLK_SRC_BIT      = 7;
    localparam int NINTH_SEL_BIT    = 6;
    localparam int XMIT_EN_BIT      = 5;
    localparam int SYNC_SEL_BIT     = 4;
    localparam int HIGH_BAUD_BIT    = 2;
    localparam int SHIFT_EMPTY_BIT  = 1;
    localparam int NINTH_DATA_BIT   = 0;
    // receive status/control fields
    localparam int PORT_EN_BIT      = 7;
    localparam int SINGLE_RECV_BIT  = 5;
    localparam int CONT_RECV_BIT    = 4;
    // flag and enable fields
    localparam int RECV_FULL_BIT    = 5;
    localparam int BUF_EMPTY_BIT    = 4;
    localparam int XMIT_IRQ_EN_BIT  = 4;

    // reset values
    localparam ustByte_t BYTE_RST       = 8'h00;
    localparam ustByte_t BAUD_DIV_RST   = 8'h00;

    // word and sampling counts
    localparam logic [3:0] WORD_BITS         = 4'h8;
    localparam logic [3:0] LONG_WORD_BITS    = 4'h9;
    localparam logic [4:0] SLOW_EDGES_PER_BIT = 5'h10;
    localparam logic [4:0] SLOW_FIRST_SAMPLE = 5'h07;
    localparam logic [4:0] FAST_EDGES_PER_BIT = 5'h08;
    localparam logic [4:0] FAST_FIRST_SAMPLE = 5'h01;
    localparam logic [4:0] SAMPLE_SPAN       = 5'h02;
    localparam logic [3:0] ASYNC_FRAME_BITS  = 4'hA;

    typedef enum logic [1:0] {
        MODE_IDLE,
        MODE_XMIT,
        MODE_RECV
    } ustMode_e;

    typedef enum logic {
        ASYNC_IDLE,
        ASYNC_RUN
    } ustAsync_e;

    typedef struct packed {
        ustAddr_t addr;
        ustByte_t wrData;
        logic     wrStrobe;
        logic     rdStrobe;
    } ustBusReq_s;

    typedef struct packed {
        logic clkOut;
        logic clkOe;
        logic dataOut;
        logic dataOe;
    } ustPins_s;

endpackage

// ---- logic/ust_serial_port.sv ----
// synchronous master serial transmitter with single/continuous receive and async bit sampler
//
// Design decisions made here: the register addresses and strobed register access.
module ust_serial_port #(
    parameter int BAUD_W = 8
) (
    // clock and reset
    input  wire logic           sys_clk,
    input  wire logic           reset_n,
    // register port
    input  wire ust_pkg::ustBusReq_s busReq,
    output      ust_pkg::ustByte_t   rdData,
    // serial pins
    output      ust_pkg::ustPins_s   pinsOut,
    input  wire logic           dataLineIn,
    // events
    output      logic           txIrq,
    output      logic           asyncBitValue,
    output      logic           asyncBitStrobe
);
    import ust_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser
    logic dataMeta_q;
    logic dataSync_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dataMeta_q <= 1'b1;
            dataSync_q <= 1'b1;
        end else begin
            dataMeta_q <= dataLineIn;
            dataSync_q <= dataMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers
    logic              clkSrc_q;
    logic              ninthSel_q;
    logic              xmitEnable_q;
    logic              syncSel_q;
    logic              highBaud_q;
    logic              ninthBit_q;
    logic              portEnable_q;
    logic              singleRecv_q;
    logic              contRecv_q;
    logic              xmitIrqEn_q;
    logic [BAUD_W-1:0] baudDiv_q;

    logic wrXmitCtrl;
    logic wrRecvCtrl;
    logic wrIrqEn;
    logic wrBuf;
    logic wrBaud;
    logic rdRecvData;
    logic recvDone;

    assign wrXmitCtrl = busReq.wrStrobe && (busReq.addr == XMIT_CTRL_OFS);
    assign wrRecvCtrl = busReq.wrStrobe && (busReq.addr == RECV_CTRL_OFS);
    assign wrIrqEn    = busReq.wrStrobe && (busReq.addr == IRQ_EN_OFS);
    assign wrBuf      = busReq.wrStrobe && (busReq.addr == XMIT_BUF_OFS);
    assign wrBaud     = busReq.wrStrobe && (busReq.addr == BAUD_DIV_OFS);
    assign rdRecvData = busReq.rdStrobe && (busReq.addr == RECV_DATA_OFS);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clkSrc_q     <= 1'b0;
            ninthSel_q   <= 1'b0;
            xmitEnable_q <= 1'b0;
            syncSel_q    <= 1'b0;
            highBaud_q   <= 1'b0;
            ninthBit_q   <= 1'b0;
        end else if (wrXmitCtrl) begin
            clkSrc_q     <= busReq.wrData[CLK_SRC_BIT];
            ninthSel_q   <= busReq.wrData[NINTH_SEL_BIT];
            xmitEnable_q <= busReq.wrData[XMIT_EN_BIT];
            syncSel_q    <= busReq.wrData[SYNC_SEL_BIT];
            highBaud_q   <= busReq.wrData[HIGH_BAUD_BIT];
            ninthBit_q   <= busReq.wrData[NINTH_DATA_BIT];
        end
    end

    // single-receive is set by software and dropped by hardware after one word
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            portEnable_q <= 1'b0;
            singleRecv_q <= 1'b0;
            contRecv_q   <= 1'b0;
        end else if (wrRecvCtrl) begin
            portEnable_q <= busReq.wrData[PORT_EN_BIT];
            singleRecv_q <= busReq.wrData[SINGLE_RECV_BIT];
            contRecv_q   <= busReq.wrData[CONT_RECV_BIT];
        end else if (recvDone && singleRecv_q) begin
            singleRecv_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            xmitIrqEn_q <= 1'b0;
            baudDiv_q   <= BAUD_W'(BAUD_DIV_RST);
        end else begin
            if (wrIrqEn) begin
                xmitIrqEn_q <= busReq.wrData[XMIT_IRQ_EN_BIT];
            end
            if (wrBaud) begin
                baudDiv_q <= busReq.wrData[BAUD_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // baud rate generator
    logic [BAUD_W-1:0] brgCnt_q;
    logic              brgRun;
    logic              brgTick;

    assign brgRun  = xmitEnable_q || contRecv_q || singleRecv_q;
    assign brgTick = brgRun && (brgCnt_q == '0);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            brgCnt_q <= '0;
        end else if (!brgRun || brgTick) begin
            brgCnt_q <= baudDiv_q;
        end else begin
            brgCnt_q <= brgCnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port mode: receive has priority, so the two directions never overlap
    logic     syncMaster;
    logic     recvReq;
    ustMode_e mode;

    assign syncMaster = syncSel_q && portEnable_q && clkSrc_q;
    assign recvReq    = contRecv_q || singleRecv_q;

    always_comb begin
        mode = MODE_IDLE;
        if (syncMaster && recvReq) begin
            mode = MODE_RECV;
        end else if (syncMaster && xmitEnable_q) begin
            mode = MODE_XMIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift clock
    logic shiftClk_q;
    logic shiftBusy_q;
    logic clkRun;
    logic clkRise;
    logic clkFall;

    assign clkRun  = (mode == MODE_RECV) || ((mode == MODE_XMIT) && shiftBusy_q);
    assign clkRise = brgTick && clkRun && !shiftClk_q;
    assign clkFall = brgTick && clkRun && shiftClk_q;

    // idles low so the first tick of a word is a rising edge
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftClk_q <= 1'b0;
        end else if (!clkRun) begin
            shiftClk_q <= 1'b0;
        end else if (brgTick) begin
            shiftClk_q <= !shiftClk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit buffer and empty flag
    ustByte_t bufData_q;
    logic     bufNinth_q;
    logic     bufFull_q;
    logic     bufEmptyFlag_q;
    logic     moveToShift;

    // one cycle after a write the word moves if the shifter is free
    assign moveToShift = bufFull_q && !shiftBusy_q && xmitEnable_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bufData_q  <= BYTE_RST;
            bufNinth_q <= 1'b0;
        end else if (wrBuf) begin
            bufData_q  <= busReq.wrData;
            bufNinth_q <= ninthBit_q;
        end
    end

    // a write in the same cycle as a move queues the new word behind it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bufFull_q      <= 1'b0;
            bufEmptyFlag_q <= 1'b1;
        end else if (wrBuf) begin
            bufFull_q      <= 1'b1;
            bufEmptyFlag_q <= 1'b0;
        end else if (moveToShift) begin
            bufFull_q      <= 1'b0;
            bufEmptyFlag_q <= 1'b1;
        end
    end

    assign txIrq = bufEmptyFlag_q && xmitIrqEn_q;

    ////////////////////////////////////////////////////////////////////////////
    // transmit shift register
    logic [8:0] shiftReg_q;
    logic [3:0] bitsLeft_q;
    logic       dataOut_q;

    // state survives a receive interruption; only transmit enable resets it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            shiftReg_q  <= '0;
            bitsLeft_q  <= '0;
            shiftBusy_q <= 1'b0;
            dataOut_q   <= 1'b0;
        end else if (!xmitEnable_q) begin
            bitsLeft_q  <= '0;
            shiftBusy_q <= 1'b0;
        end else if (moveToShift) begin
            shiftReg_q  <= {bufNinth_q, bufData_q};
            bitsLeft_q  <= ninthSel_q ? LONG_WORD_BITS : WORD_BITS;
            shiftBusy_q <= 1'b1;
        end else if ((mode == MODE_XMIT) && clkRise && (bitsLeft_q != '0)) begin
            dataOut_q   <= shiftReg_q[0];
            shiftReg_q  <= {1'b0, shiftReg_q[8:1]};
            bitsLeft_q  <= bitsLeft_q - 1'b1;
        end else if ((mode == MODE_XMIT) && clkFall && (bitsLeft_q == '0)) begin
            shiftBusy_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // synchronous receive, sampled on falling shift clock
    ustByte_t   recvShift_q;
    logic [3:0] recvCount_q;
    ustByte_t   recvData_q;
    logic       recvFull_q;

    assign recvDone = (mode == MODE_RECV) && clkFall && (recvCount_q == WORD_BITS - 1'b1);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            recvShift_q <= BYTE_RST;
            recvCount_q <= '0;
            recvData_q  <= BYTE_RST;
        end else if (mode != MODE_RECV) begin
            recvCount_q <= '0;
        end else if (clkFall) begin
            recvShift_q <= {dataSync_q, recvShift_q[7:1]};
            recvCount_q <= recvDone ? 4'h0 : recvCount_q + 1'b1;
            if (recvDone) begin
                recvData_q <= {dataSync_q, recvShift_q[7:1]};
            end
        end
    end

    // set wins over the clearing read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            recvFull_q <= 1'b0;
        end else if (recvDone) begin
            recvFull_q <= 1'b1;
        end else if (rdRecvData) begin
            recvFull_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // asynchronous receive bit sampler: each baud tick is one sampling clock edge
    ustAsync_e  asyncState_q;
    logic [4:0] phase_q;
    logic [3:0] frameBit_q;
    logic [1:0] votes_q;
    logic       asyncOn;
    logic [4:0] edgesPerBit;
    logic [4:0] firstSample;
    logic       inWindow;
    logic       bitEnd;
    logic       voteBit;

    assign asyncOn     = !syncSel_q && portEnable_q && contRecv_q;
    assign edgesPerBit = highBaud_q ? FAST_EDGES_PER_BIT : SLOW_EDGES_PER_BIT;
    assign firstSample = highBaud_q ? FAST_FIRST_SAMPLE : SLOW_FIRST_SAMPLE;
    assign inWindow    = (phase_q >= firstSample) && (phase_q <= firstSample + SAMPLE_SPAN);
    assign bitEnd      = brgTick && (phase_q == edgesPerBit - 1'b1);
    // two of three samples high (votes counted before the last one)
    assign voteBit     = (votes_q == 2'h2) || (votes_q == 2'h1 && dataSync_q) || (votes_q == 2'h3);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            asyncState_q   <= ASYNC_IDLE;
            phase_q        <= '0;
            frameBit_q     <= '0;
            votes_q        <= '0;
            asyncBitValue  <= 1'b1;
            asyncBitStrobe <= 1'b0;
        end else begin
            asyncBitStrobe <= 1'b0;
            case (asyncState_q)
                ASYNC_IDLE: begin
                    phase_q    <= '0;
                    frameBit_q <= '0;
                    votes_q    <= '0;
                    if (asyncOn && !dataSync_q) begin
                        asyncState_q <= ASYNC_RUN;
                    end
                end
                ASYNC_RUN: begin
                    if (!asyncOn) begin
                        asyncState_q <= ASYNC_IDLE;
                    end else if (brgTick) begin
                        if (inWindow && (phase_q != firstSample + SAMPLE_SPAN)) begin
                            votes_q <= votes_q + {1'b0, dataSync_q};
                        end else if (inWindow) begin
                            asyncBitValue  <= voteBit;
                            asyncBitStrobe <= 1'b1;
                        end
                        phase_q <= bitEnd ? 5'h00 : phase_q + 1'b1;
                        if (bitEnd) begin
                            votes_q    <= '0;
                            frameBit_q <= frameBit_q + 1'b1;
                            if (frameBit_q == ASYNC_FRAME_BITS - 1'b1) begin
                                asyncState_q <= ASYNC_IDLE;
                            end
                        end
                    end
                end
                default: asyncState_q <= ASYNC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins: clock driven while master and any direction is enabled
    assign pinsOut.clkOut  = shiftClk_q;
    assign pinsOut.clkOe   = syncMaster && (xmitEnable_q || recvReq);
    assign pinsOut.dataOut = dataOut_q;
    assign pinsOut.dataOe  = (mode == MODE_XMIT);

    ////////////////////////////////////////////////////////////////////////////
    // register read, data in the cycle after the strobe
    ustByte_t rdNext;

    always_comb begin
        rdNext = BYTE_RST;
        if (busReq.addr == XMIT_CTRL_OFS) begin
            rdNext[CLK_SRC_BIT]     = clkSrc_q;
            rdNext[NINTH_SEL_BIT]   = ninthSel_q;
            rdNext[XMIT_EN_BIT]     = xmitEnable_q;
            rdNext[SYNC_SEL_BIT]    = syncSel_q;
            rdNext[HIGH_BAUD_BIT]   = highBaud_q;
            rdNext[SHIFT_EMPTY_BIT] = !shiftBusy_q;
            rdNext[NINTH_DATA_BIT]  = ninthBit_q;
        end else if (busReq.addr == RECV_CTRL_OFS) begin
            rdNext[PORT_EN_BIT]     = portEnable_q;
            rdNext[SINGLE_RECV_BIT] = singleRecv_q;
            rdNext[CONT_RECV_BIT]   = contRecv_q;
        end else if (busReq.addr == FLAG_OFS) begin
            rdNext[BUF_EMPTY_BIT]   = bufEmptyFlag_q;
            rdNext[RECV_FULL_BIT]   = recvFull_q;
        end else if (busReq.addr == IRQ_EN_OFS) begin
            rdNext[XMIT_IRQ_EN_BIT] = xmitIrqEn_q;
        end else if (busReq.addr == XMIT_BUF_OFS) begin
            rdNext = bufData_q;
        end else if (busReq.addr == BAUD_DIV_OFS) begin
            rdNext[BAUD_W-1:0] = baudDiv_q;
        end else if (busReq.addr == RECV_DATA_OFS) begin
            rdNext = recvData_q;
        end
    end

    // unmapped offsets and idle cycles read as zero
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= BYTE_RST;
        end else if (busReq.rdStrobe) begin
            rdData <= rdNext;
        end else begin
            rdData <= BYTE_RST;
        end
    end

endmodule // ust_serial_port

// ---- tb/ust_serial_port_properties.sv ----
// concurrent checks on the serial port's register port and pins
module ust_serial_port_properties #(
    parameter int BAUD_W = 8
) (
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                reset_n,
    // register port
    input wire ust_pkg::ustBusReq_s busReq,
    input wire ust_pkg::ustByte_t   rdData,
    // pins and events
    input wire ust_pkg::ustPins_s   pinsOut,
    input wire logic                dataLineIn,
    input wire logic                txIrq,
    input wire logic                asyncBitValue,
    input wire logic                asyncBitStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    import ust_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // mirrors of software writes; hardware clears only make them pessimistic
    logic       transmit_enable_q;
    logic       rxEn_q;
    logic       irqEn_q;
    ustByte_t   div_q;
    logic [8:0] hiCnt_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            transmit_enable_q  <= 1'b0;
            rxEn_q  <= 1'b0;
            irqEn_q <= 1'b0;
            div_q   <= BAUD_DIV_RST;
        end else if (busReq.wrStrobe) begin
            case (busReq.addr)
                XMIT_CTRL_OFS: transmit_enable_q  <= busReq.wrData[XMIT_EN_BIT];
                RECV_CTRL_OFS: rxEn_q  <= busReq.wrData[CONT_RECV_BIT] | busReq.wrData[SINGLE_RECV_BIT];
                IRQ_EN_OFS:    irqEn_q <= busReq.wrData[XMIT_IRQ_EN_BIT];
                BAUD_DIV_OFS:  div_q   <= busReq.wrData;
                default:       div_q   <= div_q;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hiCnt_q <= 9'h000;
        end else begin
            hiCnt_q <= pinsOut.clkOut ? hiCnt_q + 9'h001 : 9'h000;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_tx_off;
        busReq.wrStrobe && busReq.addr == XMIT_CTRL_OFS && !busReq.wrData[XMIT_EN_BIT];
    endsequence
    sequence s_rx_on;
        busReq.wrStrobe && busReq.addr == RECV_CTRL_OFS && busReq.wrData[CONT_RECV_BIT];
    endsequence
    sequence s_buf_wr;
        busReq.wrStrobe && busReq.addr == XMIT_BUF_OFS;
    endsequence

    a_irq_gate: assert property (txIrq |-> irqEn_q)
        else $error("irq seen with enable clear");
    a_flag_clear: assert property (s_buf_wr |=> !txIrq)
        else $error("buffer write left empty flag set");
    a_flag_hold: assert property (busReq.wrStrobe && busReq.addr == FLAG_OFS && txIrq |=> txIrq)
        else $error("flag write cleared empty flag");
    a_bit_stable: assert property ($fell(pinsOut.clkOut) && pinsOut.dataOe |-> $stable(pinsOut.dataOut))
        else $error("data moved at falling clock");
    a_clock_quiet: assert property ($rose(pinsOut.clkOut) |-> transmit_enable_q || rxEn_q)
        else $error("shift clock ran with all enables clear");
    a_half_high: assert property ($fell(pinsOut.clkOut) && transmit_enable_q |-> hiCnt_q == {1'b0, div_q} + 9'h001)
        else $error("clock high phase length wrong");
    a_abort_float: assert property (s_tx_off |=> ##1 (!pinsOut.clkOe && !pinsOut.dataOe))
        else $error("pins still driven after transmit off");
    a_recv_float: assert property (s_rx_on |=> ##1 !pinsOut.dataOe)
        else $error("data driven while receiving");
    a_recv_clock: assert property (s_rx_on ##0 pinsOut.clkOe |=> ##1 pinsOut.clkOe)
        else $error("master clock dropped on receive");
endmodule // ust_serial_port_properties

bind ust_serial_port ust_serial_port_properties #(.BAUD_W(BAUD_W)) i_ust_serial_port_properties (
    .sys_clk(sys_clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData), .pinsOut(pinsOut),
    .dataLineIn(dataLineIn), .txIrq(txIrq), .asyncBitValue(asyncBitValue), .asyncBitStrobe(asyncBitStrobe)
);

// ---- tb/ust_sync_rx_model.sv ----
// behavioural receiver on the clock and data lines of the master
module ust_sync_rx_model (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // bench control
    input  wire logic              clear,
    // line side
    input  wire ust_pkg::ustPins_s pins,
    output      logic              lineLevel,
    // captured bits, newest at the top
    output      logic [17:0]       hist_q,
    output      logic [4:0]        count_q
);
    timeunit 1ns;
    timeprecision 1ps;
    import ust_pkg::*;
    logic prevClk_q;
    logic noise_q;
    // a floating line toggles so that a stale level never looks like data
    assign lineLevel = pins.dataOe ? pins.dataOut : noise_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prevClk_q <= 1'b0;
            noise_q   <= 1'b0;
        end else begin
            prevClk_q <= pins.clkOut;
            noise_q   <= ~noise_q;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hist_q  <= 18'h00000;
            count_q <= 5'h00;
        end else if (clear) begin
            hist_q  <= 18'h00000;
            count_q <= 5'h00;
        end else if (prevClk_q && !pins.clkOut && pins.dataOe) begin
            hist_q  <= {lineLevel, hist_q[17:1]};
            count_q <= count_q + 5'h01;
        end
    end
endmodule // ust_sync_rx_model

// ---- tb/tb_ust_serial_port.sv ----
// register-level tests of the synchronous master transmitter
module tb_ust_serial_port;
    timeunit 1ns;
    timeprecision 1ps;
    import ust_pkg::*;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    ustBusReq_s  busReq  = '0;
    ustByte_t    rdData;
    ustPins_s    pinsOut;
    logic        lineLevel;
    logic        txIrq;
    logic        clear   = 1'b0;
    logic [17:0] hist;
    logic [4:0]  count;
    int          fails    = 0;
    int          compares = 0;
    logic        rxDrive  = 1'b0;
    logic        rxLine   = 1'b1;
    logic        asyncBit;
    logic        asyncStrobe;
    int          strobes  = 0;

    always #5 sys_clk = ~sys_clk;

    ust_serial_port #(.BAUD_W(8)) i_ust_serial_port (
        .sys_clk(sys_clk), .reset_n(reset_n), .busReq(busReq), .rdData(rdData), .pinsOut(pinsOut),
        .dataLineIn(rxDrive ? rxLine : lineLevel), .txIrq(txIrq), .asyncBitValue(asyncBit),
        .asyncBitStrobe(asyncStrobe)
    );
    // one count per voted bit of the async sampler
    always @(posedge sys_clk) begin
        if (asyncStrobe === 1'b1) begin
            strobes <= strobes + 1;
        end
    end
    ust_sync_rx_model i_ust_sync_rx_model (
        .sys_clk(sys_clk), .reset_n(reset_n), .clear(clear), .pins(pinsOut),
        .lineLevel(lineLevel), .hist_q(hist), .count_q(count)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input ustAddr_t a, input ustByte_t d);
        @(posedge sys_clk);
        busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
        @(posedge sys_clk);
        busReq.wrStrobe <= 1'b0;
        #1;
    endtask
    task automatic rd(input ustAddr_t a, input ustByte_t exp);
        @(posedge sys_clk);
        busReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
        @(posedge sys_clk);
        busReq.rdStrobe <= 1'b0;
        #1;
        check(rdData, exp);
    endtask
    task automatic wait_bits(input int n);
        for (int i = 0; i < 4000 && count < n; i++) @(posedge sys_clk);
        #1;
    endtask
    task automatic clr();
        @(posedge sys_clk);
        clear <= 1'b1;
        @(posedge sys_clk);
        clear <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400us;
        fails++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(XMIT_CTRL_OFS, 8'h02);
        rd(FLAG_OFS, 8'h10);
        // divisor 7 gives a 160 ns shift clock
        wr(BAUD_DIV_OFS, 8'h07);
        wr(XMIT_CTRL_OFS, 8'h90);
        wr(RECV_CTRL_OFS, 8'h80);
        wr(IRQ_EN_OFS, 8'h10);
        check(txIrq, 1'b1);
        wr(XMIT_CTRL_OFS, 8'hB0);
        repeat (40) @(posedge sys_clk);
        #1;
        check({count, pinsOut.clkOut}, 6'h00);
        // back to back: second word queues behind the first
        wr(XMIT_BUF_OFS, 8'hA5);
        wr(XMIT_BUF_OFS, 8'h3C);
        check(txIrq, 1'b0);
        rd(XMIT_CTRL_OFS, 8'hB0);
        wait_bits(16);
        check(hist[17:2], {8'h3C, 8'hA5});
        repeat (40) @(posedge sys_clk);
        rd(XMIT_CTRL_OFS, 8'hB2);
        check(txIrq, 1'b1);
        // flag write while the enable still passes the flag out
        wr(FLAG_OFS, 8'h00);
        check(txIrq, 1'b1);
        rd(FLAG_OFS, 8'h10);
        wr(IRQ_EN_OFS, 8'h00);
        check(txIrq, 1'b0);
        // ninth bit is taken at the buffer write, later changes ignored
        clr();
        wr(XMIT_CTRL_OFS, 8'hF1);
        wr(XMIT_BUF_OFS, 8'h5A);
        wr(XMIT_CTRL_OFS, 8'hF0);
        wait_bits(9);
        check(hist[17:9], {1'b1, 8'h5A});
        repeat (40) @(posedge sys_clk);
        // receive enable in mid-word floats data, keeps the clock
        clr();
        wr(XMIT_CTRL_OFS, 8'hB0);
        wr(XMIT_BUF_OFS, 8'hFF);
        wait_bits(2);
        wr(RECV_CTRL_OFS, 8'h90);
        @(posedge sys_clk);
        #1;
        check({pinsOut.dataOe, pinsOut.clkOe}, 2'b01);
        // single word receive clears itself and hands the line back
        wr(RECV_CTRL_OFS, 8'hA0);
        repeat (160) @(posedge sys_clk);
        rd(RECV_CTRL_OFS, 8'h80);
        check(pinsOut.dataOe, 1'b1);
        rd(FLAG_OFS, 8'h30);
        wr(XMIT_CTRL_OFS, 8'h90);
        @(posedge sys_clk);
        #1;
        check({pinsOut.dataOe, pinsOut.clkOe}, 2'b00);
        rd(XMIT_CTRL_OFS, 8'h92);
        // async sampler at one tick per cycle: one low bit, then high
        wr(XMIT_CTRL_OFS, 8'h00);
        wr(BAUD_DIV_OFS, 8'h00);
        @(posedge sys_clk);
        rxDrive <= 1'b1;
        wr(RECV_CTRL_OFS, 8'h90);
        @(posedge sys_clk);
        rxLine <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rxLine <= 1'b1;
        #1;
        check(asyncBit, 1'b0);
        repeat (16) @(posedge sys_clk);
        #1;
        check(asyncBit, 1'b1);
        repeat (140) @(posedge sys_clk);
        #1;
        check(18'(strobes), 18'h0000A);
        // high rate: eight ticks per bit
        wr(XMIT_CTRL_OFS, 8'h04);
        @(posedge sys_clk);
        rxLine <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rxLine <= 1'b1;
        #1;
        check(asyncBit, 1'b0);
        repeat (8) @(posedge sys_clk);
        #1;
        check(asyncBit, 1'b1);
        end_of_test();
    end
endmodule // tb_ust_serial_port
